// [hdl/gpl_cfg.svh]
`ifndef GPL_CFG_SVH
`define GPL_CFG_SVH
`define GPL_OFS_MODE 8'h00
`define GPL_OFS_OTYPE 8'h04
`define GPL_OFS_SLEW 8'h08
`define GPL_OFS_PULL 8'h0C
`define GPL_OFS_IN 8'h10
`define GPL_OFS_OUT 8'h14
`define GPL_OFS_SETCLR 8'h18
`define GPL_OFS_FREEZE 8'h1C
`define GPL_OFS_AFL 8'h20
`define GPL_OFS_AFH 8'h24
`define GPL_OFS_CLR 8'h28
`define GPL_KEY_BIT 16
`define GPL_RST_ZERO 32'h0000_0000
`define GPL_AF_MAX_SMALL 4'h7
`endif

// [hdl/gpl_pkg.sv]
package gpl_pkg;
    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_ONE,
        KEY_ZERO,
        KEY_DONE
    } gpl_key_t;
    typedef enum logic [1:0] {
        MODE_INPUT,
        MODE_OUTPUT,
        MODE_ALT,
        MODE_ANALOG
    } gpl_mode_t;
endpackage

// [hdl/gpl_port.sv]
// Our own choice: the AHB-Lite register port.
`timescale 1ns/100ps
// Summary of operation
// RULE_01: Output value register, sixteen bits, read/write.
// RULE_02: Set/clear low half ones set outputs.
// RULE_03: Set/clear high half ones clear outputs.
// RULE_04: Set wins over clear same pin.
// RULE_05: Write-only registers read back as zero.
// RULE_06: Clear-only register low half clears outputs.
// RULE_07: Software writes key 1,0,1 then reads.
// RULE_08: Mask constant; wrong step abandons locking.
// RULE_09: Software uses word accesses during sequence.
// RULE_10: Key reads one; register frozen until reset.
// RULE_11: Locked pins ignore configuration and selector writes.
// RULE_12: Mask readable, writable only while key zero.
// RULE_13: Key bit changes only via sequence.
// RULE_14: Low selector register holds pins 0-7.
// RULE_15: High selector register holds pins 8-15.
// RULE_16: Codes above seven only on wide ports.
// RULE_17: Decode mode, type, slew, pull, input.
// RULE_18: Listed registers reset to zero.
// RULE_19: Two-bit mode field per pin.
// RULE_20: Output-type bit: push-pull or open-drain.
// RULE_21: Pins sampled into input value each cycle.
// RULE_22: Word, halfword and byte writes accepted.
// RULE_23: Set/clear effects visible at next read.
// RULE_24: Bad write returns key tracker to idle.
module gpl_port #(
    parameter int PINS = 16,
    parameter bit WIDE_AF = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [15:0] pin_in,
    output logic [15:0] pin_out,
    output logic [31:0] pin_mode,
    output logic [15:0] pin_odrain,
    output logic [31:0] pin_slew,
    output logic [31:0] pin_pull,
    output logic [63:0] pin_af,
    output logic cfg_frozen
);
`include "gpl_cfg.svh"

    if (PINS != 16) begin : g_bad_pins
        $error("gpl_port serves exactly sixteen pins");
    end

    typedef struct packed {
        logic wpend;
        logic [7:0] waddr;
        logic [2:0] wsize;
        logic [15:0] sync1;
        logic [15:0] sync2;
        logic [15:0] in_val;
        logic [15:0] out_val;
        logic [31:0] mode;
        logic [15:0] otype;
        logic [31:0] slew;
        logic [31:0] pull;
        logic [63:0] af;
        logic [15:0] mask;
        logic key;
        gpl_pkg::gpl_key_t kst;
    } gpl_state_t;

    gpl_state_t s_r;
    gpl_state_t s_nxt;

    logic [31:0] be;
    logic [31:0] wd;
    logic [7:0] wofs;
    logic [15:0] lk1;
    logic [31:0] lk2;
    logic [63:0] lk4;
    logic [63:0] af_new;
    logic [31:0] sc;

    // Byte-lane mask from latched size and address
    always_comb begin
        be = 32'h0000_0000;
        case (s_r.wsize)
            3'd0: be[s_r.waddr[1:0]*8 +: 8] = 8'hFF; // [RULE_22]
            3'd1: be[s_r.waddr[1]*16 +: 16] = 16'hFFFF; // [RULE_22]
            default: be = 32'hFFFF_FFFF; // [RULE_22]
        endcase
        wd = hwdata & be;
    end
    assign wofs = {s_r.waddr[7:2], 2'b00};

    // Per-pin lock expansion for 1-bit, 2-bit and 4-bit fields
    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : g_lk
            assign lk1[g] = s_r.mask[g] & s_r.key; // [RULE_11]
            assign lk2[2*g +: 2] = {2{s_r.mask[g] & s_r.key}}; // [RULE_11]
            assign lk4[4*g +: 4] = {4{s_r.mask[g] & s_r.key}}; // [RULE_11]
            assign af_new[4*g +: 4] =
                (!WIDE_AF && hwdata[4*(g%8)+3])
                    ? s_r.af[4*g +: 4] : hwdata[4*(g%8) +: 4]; // [RULE_16]
        end
    endgenerate

    always_comb begin
        s_nxt = s_r;
        s_nxt.sync1 = pin_in;
        s_nxt.sync2 = s_r.sync1;
        s_nxt.in_val = s_r.sync2; // [RULE_21]
        sc = 32'h0000_0000;
        s_nxt.wpend = 1'b0;
        if (s_r.wpend) begin
            case (wofs)
                `GPL_OFS_MODE:
                    s_nxt.mode = (s_r.mode & (lk2 | ~be)) |
                        (wd & ~lk2); // [RULE_11] [RULE_19]
                `GPL_OFS_OTYPE:
                    s_nxt.otype = (s_r.otype & (lk1 | ~be[15:0])) |
                        (wd[15:0] & ~lk1); // [RULE_11] [RULE_20]
                `GPL_OFS_SLEW:
                    s_nxt.slew = (s_r.slew & (lk2 | ~be)) | (wd & ~lk2);
                `GPL_OFS_PULL:
                    s_nxt.pull = (s_r.pull & (lk2 | ~be)) | (wd & ~lk2);
                `GPL_OFS_OUT:
                    s_nxt.out_val = (s_r.out_val & ~be[15:0]) |
                        wd[15:0]; // [RULE_01]
                `GPL_OFS_SETCLR:
                    sc = wd; // [RULE_02] [RULE_03]
                `GPL_OFS_CLR:
                    sc = {wd[15:0], 16'h0000}; // [RULE_06]
                `GPL_OFS_AFL:
                    s_nxt.af[31:0] = (s_r.af[31:0] & (lk4[31:0] | ~be)) |
                        (af_new[31:0] & be & ~lk4[31:0]); // [RULE_14]
                `GPL_OFS_AFH:
                    s_nxt.af[63:32] = (s_r.af[63:32] &
                        (lk4[63:32] | ~be)) |
                        (af_new[63:32] & be & ~lk4[63:32]); // [RULE_15]
                `GPL_OFS_FREEZE: begin
                    if (!s_r.key) begin
                        s_nxt.mask = (s_r.mask & ~be[15:0]) |
                            wd[15:0]; // [RULE_12]
                        // Key sequence tracker
                        if (s_r.wsize != 3'd2) begin
                            s_nxt.kst = gpl_pkg::KEY_IDLE; // [RULE_24]
                        end else begin
                            case (s_r.kst)
                                gpl_pkg::KEY_IDLE: begin
                                    s_nxt.mask = hwdata[15:0];
                                    if (hwdata[`GPL_KEY_BIT]) begin
                                        s_nxt.kst = gpl_pkg::KEY_ONE;
                                    end
                                end
                                gpl_pkg::KEY_ONE:
                                    if (!hwdata[`GPL_KEY_BIT] &&
                                        hwdata[15:0] == s_r.mask) begin
                                        s_nxt.kst = gpl_pkg::KEY_ZERO;
                                    end else begin
                                        s_nxt.kst =
                                            gpl_pkg::KEY_IDLE; // [RULE_08]
                                    end
                                gpl_pkg::KEY_ZERO:
                                    if (hwdata[`GPL_KEY_BIT] &&
                                        hwdata[15:0] == s_r.mask) begin
                                        s_nxt.key = 1'b1; // [RULE_13]
                                        s_nxt.kst = gpl_pkg::KEY_DONE;
                                    end else begin
                                        s_nxt.kst =
                                            gpl_pkg::KEY_IDLE; // [RULE_24]
                                    end
                                default: s_nxt.kst = gpl_pkg::KEY_IDLE;
                            endcase
                        end
                    end
                end
                default: ;
            endcase
        end
        // Clear first then set so set wins
        s_nxt.out_val = (s_nxt.out_val & ~sc[31:16]) | sc[15:0]; // [RULE_04]
        if (hsel && hready && htrans[1]) begin
            s_nxt.wpend = hwrite;
            s_nxt.waddr = haddr[7:0];
            s_nxt.wsize = hsize;
        end
        if (hsel && hready && htrans[1] && !hwrite) begin
            s_nxt.waddr = haddr[7:0];
        end
    end

    // Read data: registered one cycle after address phase
    logic [31:0] rd_now;
    always_comb begin
        case ({haddr[7:2], 2'b00})
            `GPL_OFS_MODE: rd_now = s_nxt.mode; // [RULE_17]
            `GPL_OFS_OTYPE: rd_now = {16'h0000, s_nxt.otype}; // [RULE_17]
            `GPL_OFS_SLEW: rd_now = s_nxt.slew; // [RULE_17]
            `GPL_OFS_PULL: rd_now = s_nxt.pull; // [RULE_17]
            `GPL_OFS_IN: rd_now = {16'h0000, s_r.in_val}; // [RULE_17]
            `GPL_OFS_OUT: rd_now = {16'h0000, s_nxt.out_val}; // [RULE_23]
            `GPL_OFS_FREEZE:
                rd_now = {15'h0000, s_nxt.key, s_nxt.mask}; // [RULE_10]
            `GPL_OFS_AFL: rd_now = s_nxt.af[31:0];
            `GPL_OFS_AFH: rd_now = s_nxt.af[63:32];
            default: rd_now = 32'h0000_0000; // [RULE_05]
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_r <= '0; // [RULE_18]
            s_r.kst <= gpl_pkg::KEY_IDLE;
            hrdata <= `GPL_RST_ZERO;
        end else begin
            s_r <= s_nxt;
            if (hsel && hready && htrans[1] && !hwrite) begin
                hrdata <= rd_now;
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign pin_out = s_r.out_val;
    assign pin_mode = s_r.mode;
    assign pin_odrain = s_r.otype;
    assign pin_slew = s_r.slew;
    assign pin_pull = s_r.pull;
    assign pin_af = s_r.af;
    assign cfg_frozen = s_r.key;

    // Assertions
    property p_set_wins;
        @(posedge clk_sys) disable iff (rst)
        (s_r.wpend && s_r.waddr == `GPL_OFS_SETCLR)
            |=> ((s_r.out_val & $past(wd[15:0])) == $past(wd[15:0]));
    endproperty
    set_wins_a: assert property (p_set_wins) // [RULE_04]
        else $error("set request did not set output");

    clr_only_a: assert property ( // [RULE_06]
        @(posedge clk_sys) disable iff (rst)
        (s_r.wpend && s_r.waddr == `GPL_OFS_CLR)
            |=> ((s_r.out_val & $past(wd[15:0])) == 16'h0000))
        else $error("clear-only write did not clear");

    key_sticky_a: assert property ( // [RULE_10]
        @(posedge clk_sys) disable iff (rst)
        s_r.key |=> s_r.key)
        else $error("key bit fell without reset");

    sequence s_k1;
        s_r.kst == gpl_pkg::KEY_ONE;
    endsequence
    key_path_a: assert property ( // [RULE_13]
        @(posedge clk_sys) disable iff (rst)
        $rose(s_r.key) |-> $past(s_r.kst) == gpl_pkg::KEY_ZERO)
        else $error("key set outside sequence");

    mask_hold_a: assert property ( // [RULE_12]
        @(posedge clk_sys) disable iff (rst)
        s_r.key |=> $stable(s_r.mask))
        else $error("mask changed while key set");

    lock_mode_a: assert property ( // [RULE_11]
        @(posedge clk_sys) disable iff (rst)
        s_r.key |=> ((s_r.mode ^ $past(s_r.mode)) & $past(lk2)) == 0)
        else $error("locked pin mode changed");

    bad_size_a: assert property ( // [RULE_24]
        @(posedge clk_sys) disable iff (rst)
        (s_r.wpend && s_r.waddr == `GPL_OFS_FREEZE && s_r.wsize != 3'd2)
            |=> s_r.kst == gpl_pkg::KEY_IDLE)
        else $error("tracker not reset by narrow write");

    input_smp_a: assert property ( // [RULE_21]
        @(posedge clk_sys) disable iff (rst)
        !rst |-> ##3 s_r.in_val == $past(pin_in, 3))
        else $error("input value not sampled");

    out_ro_a: assert property ( // [RULE_05]
        @(posedge clk_sys) disable iff (rst)
        (hsel && hready && htrans[1] && !hwrite &&
         haddr[7:0] == `GPL_OFS_SETCLR) |=> hrdata == 32'h0000_0000)
        else $error("set/clear read not zero");

    wrong_step_a: assert property ( // [RULE_08]
        @(posedge clk_sys) disable iff (rst)
        (s_k1 and s_r.wpend && s_r.waddr == `GPL_OFS_FREEZE
         && !s_r.key && hwdata[`GPL_KEY_BIT])
            |=> s_r.kst == gpl_pkg::KEY_IDLE)
        else $error("wrong step not abandoned");

    lock_otype_a: assert property ( // [RULE_11]
        @(posedge clk_sys) disable iff (rst)
        s_r.key |=> ((s_r.otype ^ $past(s_r.otype)) & $past(lk1)) == 0)
        else $error("locked pin output type changed");

    lock_af_a: assert property ( // [RULE_11]
        @(posedge clk_sys) disable iff (rst)
        s_r.key |=> ((s_r.af ^ $past(s_r.af)) & $past(lk4)) == 0)
        else $error("locked pin selector changed");

    lock_drive_a: assert property ( // [RULE_11]
        @(posedge clk_sys) disable iff (rst)
        s_r.key |=> (((s_r.slew ^ $past(s_r.slew)) |
            (s_r.pull ^ $past(s_r.pull))) & $past(lk2)) == 0)
        else $error("locked pin slew or pull changed");

    sequence s_sc_wr;
        s_r.wpend && wofs == `GPL_OFS_SETCLR;
    endsequence

    clr_half_a: assert property ( // [RULE_03]
        @(posedge clk_sys) disable iff (rst)
        s_sc_wr |=>
            (s_r.out_val & $past(wd[31:16] & ~wd[15:0])) == 16'h0000)
        else $error("clear request did not clear output");

    sc_keep_a: assert property ( // [RULE_02]
        @(posedge clk_sys) disable iff (rst)
        s_sc_wr |=> ((s_r.out_val ^ $past(s_r.out_val)) &
            ~$past(wd[31:16] | wd[15:0])) == 16'h0000)
        else $error("set/clear touched an unrequested pin");

    clr_read_a: assert property ( // [RULE_05]
        @(posedge clk_sys) disable iff (rst)
        (hsel && hready && htrans[1] && !hwrite &&
         haddr[7:0] == `GPL_OFS_CLR) |=> hrdata == 32'h0000_0000)
        else $error("clear-only read not zero");

    mask_write_a: assert property ( // [RULE_12]
        @(posedge clk_sys) disable iff (rst)
        (s_r.wpend && wofs == `GPL_OFS_FREEZE && !s_r.key &&
         s_r.wsize == 3'd2) |=> s_r.mask == $past(hwdata[15:0]))
        else $error("mask write while key clear was lost");
endmodule

// [tb/test_gpl_port.sv]
`timescale 1ns/100ps
module test_gpl_port;
    localparam logic [2:0] W = 3'b010;
    logic clk_sys;
    logic rst;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [15:0] pin_in;
    logic [15:0] pin_out;
    logic [31:0] pin_mode;
    logic [15:0] pin_odrain;
    logic [31:0] pin_slew;
    logic [31:0] pin_pull;
    logic [63:0] pin_af;
    logic cfg_frozen;
    logic [31:0] rdv;
    int n_errors;
    int checks;

    gpl_port uut (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out),
        .pin_mode(pin_mode), .pin_odrain(pin_odrain), .pin_slew(pin_slew),
        .pin_pull(pin_pull), .pin_af(pin_af), .cfg_frozen(cfg_frozen));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Wait for the slave to accept the current phase
    task automatic wrdy();
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
    endtask

    task automatic aph(input logic [31:0] a, input logic w,
                       input logic [2:0] sz);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= sz;
        wrdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d,
                      input logic [2:0] sz);
        aph(a, 1'b1, sz);
        hwdata <= d;
        wrdy();
    endtask

    // Read data is taken at the edge that ends the data phase
    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        aph(a, 1'b0, W);
        wrdy();
        rdv = hrdata;
        chk(rdv, exp);
        chk({31'h0, hresp}, 32'h0000_0000);
    endtask

    task automatic t_reset();
        for (int i = 0; i < 12; i++) begin
            if (i != 4) rdc(32'(i * 4), 32'h0000_0000);
        end
        chk({16'h0, pin_out}, 32'h0000_0000);
    endtask

    task automatic t_out();
        wr(32'h0000_0014, 32'hFFFF_A5C3, W);
        rdc(32'h0000_0014, 32'h0000_A5C3);
        chk({16'h0, pin_out}, 32'h0000_A5C3);
    endtask

    // Set 0x0030, clear 0x00D3, pin 4 both: set wins
    task automatic t_setclr();
        wr(32'h0000_0018, 32'h00D3_0030, W);
        rdc(32'h0000_0014, 32'h0000_A530);
        chk({16'h0, pin_out}, 32'h0000_A530);
        rdc(32'h0000_0018, 32'h0000_0000);
    endtask

    task automatic t_clronly();
        wr(32'h0000_0028, 32'hFFFF_0500, W);
        rdc(32'h0000_0014, 32'h0000_A030);
        rdc(32'h0000_0028, 32'h0000_0000);
    endtask

    task automatic t_af();
        wr(32'h0000_0020, 32'h89AB_CDEF, W);
        wr(32'h0000_0024, 32'h7654_3210, W);
        rdc(32'h0000_0020, 32'h89AB_CDEF);
        rdc(32'h0000_0024, 32'h7654_3210);
        chk(pin_af[31:0], 32'h89AB_CDEF);
        chk(pin_af[63:32], 32'h7654_3210);
    endtask

    task automatic t_cfg();
        wr(32'h0000_0000, 32'h0000_00A9, W);
        wr(32'h0000_0001, 32'h0000_5500, 3'b000);
        wr(32'h0000_0004, 32'h0000_800D, W);
        wr(32'h0000_0008, 32'hC3C3_0000, W);
        wr(32'h0000_000E, 32'h1234_0000, 3'b001);
        rdc(32'h0000_0000, 32'h0000_55A9);
        chk(pin_mode, 32'h0000_55A9);
        chk({16'h0, pin_odrain}, 32'h0000_800D);
        chk(pin_slew, 32'hC3C3_0000);
        chk(pin_pull, 32'h1234_0000);
    endtask

    task automatic t_input();
        pin_in <= 16'h3C5A;
        repeat (4) @(posedge clk_sys);
        rdc(32'h0000_0010, 32'h0000_3C5A);
    endtask

    task automatic t_lock();
        wr(32'h0000_001C, 32'h0001_0003, W);
        wr(32'h0000_001C, 32'h0001_0003, W);
        wr(32'h0000_001C, 32'h0000_0003, W);
        wr(32'h0000_001C, 32'h0001_0003, W);
        wr(32'h0000_001C, 32'h0000_0003, W);
        wr(32'h0000_001C, 32'h0001_0003, 3'b001);
        rdc(32'h0000_001C, 32'h0000_0003);
        wr(32'h0000_001C, 32'h0001_0003, W);
        wr(32'h0000_001C, 32'h0000_0003, W);
        wr(32'h0000_001C, 32'h0001_0003, W);
        rdc(32'h0000_001C, 32'h0001_0003);
        chk({31'h0, cfg_frozen}, 32'h0000_0001);
    endtask

    // Pins 0 and 1 are frozen, the rest still take writes
    task automatic t_locked();
        wr(32'h0000_0000, 32'hFFFF_FFFF, W);
        wr(32'h0000_0004, 32'h0000_0000, W);
        wr(32'h0000_0020, 32'h0000_0000, W);
        wr(32'h0000_001C, 32'h0000_FFFF, W);
        rdc(32'h0000_0000, 32'hFFFF_FFF9);
        rdc(32'h0000_0004, 32'h0000_0001);
        rdc(32'h0000_0020, 32'h0000_00EF);
        rdc(32'h0000_001C, 32'h0001_0003);
    endtask

    task automatic t_reset2();
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rdc(32'h0000_001C, 32'h0000_0000);
        chk({31'h0, cfg_frozen}, 32'h0000_0000);
        wr(32'h0000_0020, 32'h0000_0055, W);
        rdc(32'h0000_0020, 32'h0000_0055);
    endtask

    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk_sys);
        n_errors++;
        end_of_test();
    end

    initial begin
        n_errors = 0;
        checks = 0;
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = W;
        hwdata = 32'h0000_0000;
        pin_in = 16'h0000;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_out();
        t_setclr();
        t_clronly();
        t_af();
        t_cfg();
        t_input();
        t_lock();
        t_locked();
        t_reset2();
        end_of_test();
    end
endmodule
